// *** inc/legacy_timer_map.vh ***
`ifndef LEGACY_TIMER_MAP_VH
`define LEGACY_TIMER_MAP_VH

// --------------------------------------------------------------
// Register addresses on the special function register bus
// --------------------------------------------------------------
`define ADDR_TIMER_CONTROL_STATUS 8'h88
`define ADDR_TIMER_MODE_CONFIG 8'h89
`define ADDR_TIMER0_LOW_BYTE 8'h8a
`define ADDR_TIMER1_LOW_BYTE 8'h8b
`define ADDR_TIMER0_HIGH_BYTE 8'h8c
`define ADDR_TIMER1_HIGH_BYTE 8'h8d
`define ADDR_TIMER_CLOCK_SELECT 8'h8e

// --------------------------------------------------------------
// Control/status bit positions
// --------------------------------------------------------------
`define BIT_TIMER1_OVERFLOW_FLAG 7
`define BIT_TIMER1_RUN 6
`define BIT_TIMER0_OVERFLOW_FLAG 5
`define BIT_TIMER0_RUN 4
`define BIT_EXT_IRQ_B_FLAG 3
`define BIT_EXT_IRQ_B_TYPE 2
`define BIT_EXT_IRQ_A_FLAG 1
`define BIT_EXT_IRQ_A_TYPE 0

// --------------------------------------------------------------
// Mode config fields (per-timer nibble: gate, select, mode[1:0])
// --------------------------------------------------------------
`define BIT_TIMER1_GATE_CTL 7
`define BIT_TIMER1_COUNT_SELECT 6
`define BIT_TIMER0_GATE_CTL 3
`define BIT_TIMER0_COUNT_SELECT 2
`define MODE_13BIT 2'b00
`define MODE_16BIT 2'b01
`define MODE_RELOAD 2'b10
`define MODE_SPLIT 2'b11

// --------------------------------------------------------------
// Clock select bit positions
// --------------------------------------------------------------
`define BIT_TIMER3_HI_CLK_SELECT 7
`define BIT_TIMER3_LO_CLK_SELECT 6
`define BIT_TIMER2_HI_CLK_SELECT 5
`define BIT_TIMER2_LO_CLK_SELECT 4
`define BIT_TIMER1_CLK_SELECT 3
`define BIT_TIMER0_CLK_SELECT 2

// --------------------------------------------------------------
// Prescaler codes and division ratios
// --------------------------------------------------------------
`define PRESCALE_DIV12 2'b00
`define PRESCALE_DIV4 2'b01
`define PRESCALE_DIV48 2'b10
`define PRESCALE_EXT8 2'b11
`define DIV_COUNT_12 6'h0b
`define DIV_COUNT_4 6'h03
`define DIV_COUNT_48 6'h2f
`define EXT_DIV_COUNT_8 3'h7

`define RESET_BYTE 8'h00

`endif

// *** verilog/timer_byte_counter.v ***
`timescale 1ns/10ps
// --------------------------------------------------------------
// One 8-bit count stage with carry in and carry out
// --------------------------------------------------------------
module timer_byte_counter #(
	parameter WIDTH = 8
) (
	input wire [WIDTH-1:0] i_value,
	input wire i_carry,
	output wire [WIDTH-1:0] o_next,
	output wire o_carry
);
	assign o_next = i_value + {{(WIDTH-1){1'b0}}, i_carry};
	assign o_carry = i_carry & (&i_value);
endmodule // timer_byte_counter

// *** verilog/dual_legacy_counter_timer.v ***
// How it works
// - Timer counts when run set and gate off or its irq input active.
// - Setting run never clears or reloads the count bytes.
// - Timer 1 has the same 13-bit mode using its own bits.
// - Timer 1 gates on input b with its own polarity bit.
// - 13-bit mode: high byte bits 12-5, low bits 4-0; wrap sets flag.
// - 16-bit mode counts all sixteen bits; wrap from all ones sets flag.
// - Reload mode: low byte counts, wrap sets flag and reloads from high.
// - Split mode: timer 0 low byte uses timer 0 run, select, gate, flag.
// - Split high byte ticks internally, runs on timer1 run, sets flag 1.
// - During split, timer 1 ignores its pin and never sets its flag.
// - During split, timer 1 runs in modes 0-2 and stops in mode 3.
// - Timer 1 overflow pulse stays exported even during split.
// - Overflow flags set by hardware, cleared on vector or by write.
// - Level mode flag sets while input active, cleared only by write; edge mode sets, vector clears.
// - Type bit 0 selects level, 1 selects edge triggering.
// - Select 1 counts pin falling edges, 0 counts the internal tick.
// - Mode 00 13-bit, 01 16-bit, 10 reload, 11 split/inactive.
// - Clock select 1 is system clock, 0 prescaled; ignored for pin count.
// - Prescale 00 div 12, 01 div 4, 10 div 48, 11 external div 8.
// - External div 8 is synchronised before use as a tick.
// - Timer 2/3 clock select bits are held in the clock register.
`timescale 1ns/10ps
`include "legacy_timer_map.vh"

module dual_legacy_counter_timer (
	input wire i_sys_clk,
	input wire i_arst_n,
	input wire [7:0] i_sfr_addr,
	input wire i_sfr_wr,
	input wire [7:0] i_sfr_wdata,
	output reg [7:0] o_sfr_rdata,
	input wire i_vector_timer0,
	input wire i_vector_timer1,
	input wire i_vector_ext_a,
	input wire i_vector_ext_b,
	input wire i_ext_irq_in_a,
	input wire i_ext_irq_in_b,
	input wire i_ext_irq_a_polarity,
	input wire i_ext_irq_b_polarity,
	input wire i_count_pin_a,
	input wire i_count_pin_b,
	input wire i_ext_osc_clk,
	output reg o_timer0_overflow,
	output reg o_timer1_overflow,
	output reg o_timer0_high_overflow,
	output reg o_timer0_irq,
	output reg o_timer1_irq,
	output reg o_ext_irq_a,
	output reg o_ext_irq_b
);
	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	reg [7:0] timer_control_status;
	reg [7:0] timer_mode_config;
	reg [7:0] timer_clock_select;
	reg [7:0] timer0_low_byte;
	reg [7:0] timer0_high_byte;
	reg [7:0] timer1_low_byte;
	reg [7:0] timer1_high_byte;
	reg [1:0] sync_irq_a;
	reg [1:0] sync_irq_b;
	reg [1:0] sync_pin_a;
	reg [1:0] sync_pin_b;
	reg [1:0] sync_osc;
	reg last_irq_a;
	reg last_irq_b;
	reg last_pin_a;
	reg last_pin_b;
	reg last_osc;
	reg [2:0] sync_fill;
	reg [2:0] osc_div;
	reg [5:0] pre_div;
	reg [5:0] next_pre_div;

	wire write_timer_control_status = i_sfr_wr &
		(i_sfr_addr == `ADDR_TIMER_CONTROL_STATUS);

	// --------------------------------------------------------------
	// Input synchronisers and edge detection
	// --------------------------------------------------------------
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync_irq_a <= 2'h0;
			sync_irq_b <= 2'h0;
			sync_pin_a <= 2'h0;
			sync_pin_b <= 2'h0;
			sync_osc <= 2'h0;
			last_irq_a <= 1'b0;
			last_irq_b <= 1'b0;
			last_pin_a <= 1'b0;
			last_pin_b <= 1'b0;
			last_osc <= 1'b0;
			sync_fill <= 3'h0;
		end else begin
			sync_irq_a <= {sync_irq_a[0], i_ext_irq_in_a};
			sync_irq_b <= {sync_irq_b[0], i_ext_irq_in_b};
			sync_pin_a <= {sync_pin_a[0], i_count_pin_a};
			sync_pin_b <= {sync_pin_b[0], i_count_pin_b};
			sync_osc <= {sync_osc[0], i_ext_osc_clk};
			last_irq_a <= sync_irq_a[1];
			last_irq_b <= sync_irq_b[1];
			last_pin_a <= sync_pin_a[1];
			last_pin_b <= sync_pin_b[1];
			last_osc <= sync_osc[1];
			sync_fill <= {sync_fill[1:0], 1'b1};
		end
	end

	// Active level after polarity; masked until the flops hold real samples
	wire act_a = sync_fill[2] & ~(sync_irq_a[1] ^ i_ext_irq_a_polarity);
	wire act_a_last = sync_fill[2] & ~(last_irq_a ^ i_ext_irq_a_polarity);
	wire act_b = sync_fill[2] & ~(sync_irq_b[1] ^ i_ext_irq_b_polarity);
	wire act_b_last = sync_fill[2] & ~(last_irq_b ^ i_ext_irq_b_polarity);
	wire fall_pin_a = last_pin_a & ~sync_pin_a[1];
	wire fall_pin_b = last_pin_b & ~sync_pin_b[1];
	wire osc_rise = sync_osc[1] & ~last_osc;

	// --------------------------------------------------------------
	// Shared prescaler
	// --------------------------------------------------------------
	reg [5:0] div_top;
	always @* begin
		case (timer_clock_select[1:0])
		`PRESCALE_DIV12: div_top = `DIV_COUNT_12;
		`PRESCALE_DIV4: div_top = `DIV_COUNT_4;
		`PRESCALE_DIV48: div_top = `DIV_COUNT_48;
		default: div_top = `DIV_COUNT_12;
		endcase
		next_pre_div = (pre_div >= div_top) ? 6'h00 : pre_div + 6'h01;
	end

	wire int_tick = (pre_div >= div_top);
	// Oscillator edges counted only after synchronising, so the tick is
	// a clean one-cycle pulse in the system domain
	wire ext_tick = osc_rise & (osc_div == `EXT_DIV_COUNT_8);
	wire pre_tick = (timer_clock_select[1:0] == `PRESCALE_EXT8) ?
		ext_tick : int_tick;

	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pre_div <= 6'h00;
			osc_div <= 3'h0;
		end else begin
			pre_div <= next_pre_div;
			if (osc_rise)
				osc_div <= osc_div + 3'h1;
		end
	end

	// --------------------------------------------------------------
	// Tick selection and enables
	// --------------------------------------------------------------
	wire [1:0] mode0 = timer_mode_config[1:0];
	wire [1:0] mode1 = timer_mode_config[5:4];
	wire split = (mode0 == `MODE_SPLIT);
	wire run0 = timer_control_status[`BIT_TIMER0_RUN];
	wire run1 = timer_control_status[`BIT_TIMER1_RUN];
	wire clk_tick0 = timer_clock_select[`BIT_TIMER0_CLK_SELECT] ?
		1'b1 : pre_tick;
	wire clk_tick1 = timer_clock_select[`BIT_TIMER1_CLK_SELECT] ?
		1'b1 : pre_tick;
	wire tick0 = timer_mode_config[`BIT_TIMER0_COUNT_SELECT] ?
		fall_pin_a : clk_tick0;
	wire tick1 = (timer_mode_config[`BIT_TIMER1_COUNT_SELECT] & ~split) ?
		fall_pin_b : clk_tick1;
	wire en0 = run0 & (~timer_mode_config[`BIT_TIMER0_GATE_CTL] |
		act_a);
	wire en1_norm = run1 & (~timer_mode_config[`BIT_TIMER1_GATE_CTL] |
		act_b);
	wire en1 = split ? (mode1 != `MODE_SPLIT) :
		(en1_norm & (mode1 != `MODE_SPLIT));
	wire inc0 = en0 & tick0;
	wire inc1 = en1 & tick1;
	wire inc0h = run1 & clk_tick0;

	// --------------------------------------------------------------
	// Count stages
	// --------------------------------------------------------------
	wire [7:0] t0_lo_n;
	wire [7:0] t0_hi_n;
	wire [7:0] t1_lo_n;
	wire [7:0] t1_hi_n;
	wire t0_lo_c;
	wire t0_hi_c;
	wire t1_lo_c;
	wire t1_hi_c;
	wire [7:0] t0_lo_in = (mode0 == `MODE_13BIT) ?
		{3'h0, timer0_low_byte[4:0]} : timer0_low_byte;
	wire [7:0] t1_lo_in = (mode1 == `MODE_13BIT) ?
		{3'h0, timer1_low_byte[4:0]} : timer1_low_byte;
	// 13-bit carry comes from the fifth bit of the low byte
	wire t0_lo_wrap = (mode0 == `MODE_13BIT) ?
		(inc0 & (&timer0_low_byte[4:0])) : t0_lo_c;
	wire t1_lo_wrap = (mode1 == `MODE_13BIT) ?
		(inc1 & (&timer1_low_byte[4:0])) : t1_lo_c;

	timer_byte_counter #(.WIDTH(8)) u_t0_lo (
		.i_value(t0_lo_in), .i_carry(inc0),
		.o_next(t0_lo_n), .o_carry(t0_lo_c));
	timer_byte_counter #(.WIDTH(8)) u_t0_hi (
		.i_value(timer0_high_byte),
		.i_carry(split ? inc0h : t0_lo_wrap),
		.o_next(t0_hi_n), .o_carry(t0_hi_c));
	timer_byte_counter #(.WIDTH(8)) u_t1_lo (
		.i_value(t1_lo_in), .i_carry(inc1),
		.o_next(t1_lo_n), .o_carry(t1_lo_c));
	timer_byte_counter #(.WIDTH(8)) u_t1_hi (
		.i_value(timer1_high_byte), .i_carry(t1_lo_wrap),
		.o_next(t1_hi_n), .o_carry(t1_hi_c));

	wire ovf0 = (mode0 == `MODE_13BIT || mode0 == `MODE_16BIT) ?
		t0_hi_c : t0_lo_c;
	wire ovf0h = split & t0_hi_c;
	wire ovf1 = (mode1 == `MODE_RELOAD) ? t1_lo_c : t1_hi_c;
	wire set_tf1 = split ? ovf0h : ovf1;

	// --------------------------------------------------------------
	// Register writes and count updates
	// --------------------------------------------------------------
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			timer_control_status <= `RESET_BYTE;
			timer_mode_config <= `RESET_BYTE;
			timer_clock_select <= `RESET_BYTE;
			timer0_low_byte <= `RESET_BYTE;
			timer0_high_byte <= `RESET_BYTE;
			timer1_low_byte <= `RESET_BYTE;
			timer1_high_byte <= `RESET_BYTE;
		end else begin
			// Writes only store; run never touches the count bytes
			if (write_timer_control_status)
				timer_control_status <= i_sfr_wdata;
			if (i_sfr_wr && i_sfr_addr == `ADDR_TIMER_MODE_CONFIG)
				timer_mode_config <= i_sfr_wdata;
			if (i_sfr_wr && i_sfr_addr == `ADDR_TIMER_CLOCK_SELECT)
				timer_clock_select <= i_sfr_wdata;
			// Timer 0 low byte
			if (i_sfr_wr && i_sfr_addr == `ADDR_TIMER0_LOW_BYTE)
				timer0_low_byte <= i_sfr_wdata;
			else if (mode0 == `MODE_RELOAD && t0_lo_c)
				timer0_low_byte <= timer0_high_byte;
			else if (inc0)
				timer0_low_byte <= t0_lo_n;
			// Timer 0 high byte; holds the reload value in mode 2
			if (i_sfr_wr && i_sfr_addr == `ADDR_TIMER0_HIGH_BYTE)
				timer0_high_byte <= i_sfr_wdata;
			else if (mode0 != `MODE_RELOAD)
				timer0_high_byte <= t0_hi_n;
			// Timer 1 low byte
			if (i_sfr_wr && i_sfr_addr == `ADDR_TIMER1_LOW_BYTE)
				timer1_low_byte <= i_sfr_wdata;
			else if (mode1 == `MODE_RELOAD && t1_lo_c)
				timer1_low_byte <= timer1_high_byte;
			else if (inc1)
				timer1_low_byte <= t1_lo_n;
			if (i_sfr_wr && i_sfr_addr == `ADDR_TIMER1_HIGH_BYTE)
				timer1_high_byte <= i_sfr_wdata;
			else if (mode1 != `MODE_RELOAD)
				timer1_high_byte <= t1_hi_n;
			// Hardware set wins over a software or vector clear
			if (ovf0)
				timer_control_status[`BIT_TIMER0_OVERFLOW_FLAG] <=
					1'b1;
			else if (i_vector_timer0)
				timer_control_status[`BIT_TIMER0_OVERFLOW_FLAG] <=
					1'b0;
			if (set_tf1)
				timer_control_status[`BIT_TIMER1_OVERFLOW_FLAG] <=
					1'b1;
			else if (i_vector_timer1)
				timer_control_status[`BIT_TIMER1_OVERFLOW_FLAG] <=
					1'b0;
			// External interrupt flags
			if (!timer_control_status[`BIT_EXT_IRQ_A_TYPE]) begin
				if (act_a)
					timer_control_status[`BIT_EXT_IRQ_A_FLAG] <=
						1'b1;
			end else if (act_a & ~act_a_last) begin
				timer_control_status[`BIT_EXT_IRQ_A_FLAG] <= 1'b1;
			end else if (i_vector_ext_a) begin
				timer_control_status[`BIT_EXT_IRQ_A_FLAG] <= 1'b0;
			end
			if (!timer_control_status[`BIT_EXT_IRQ_B_TYPE]) begin
				if (act_b)
					timer_control_status[`BIT_EXT_IRQ_B_FLAG] <=
						1'b1;
			end else if (act_b & ~act_b_last) begin
				timer_control_status[`BIT_EXT_IRQ_B_FLAG] <= 1'b1;
			end else if (i_vector_ext_b) begin
				timer_control_status[`BIT_EXT_IRQ_B_FLAG] <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// Read mux and registered outputs
	// --------------------------------------------------------------
	reg [7:0] next_rdata;
	always @* begin
		case (i_sfr_addr)
		`ADDR_TIMER_CONTROL_STATUS: next_rdata = timer_control_status;
		`ADDR_TIMER_MODE_CONFIG: next_rdata = timer_mode_config;
		`ADDR_TIMER0_LOW_BYTE: next_rdata = timer0_low_byte;
		`ADDR_TIMER1_LOW_BYTE: next_rdata = timer1_low_byte;
		`ADDR_TIMER0_HIGH_BYTE: next_rdata = timer0_high_byte;
		`ADDR_TIMER1_HIGH_BYTE: next_rdata = timer1_high_byte;
		`ADDR_TIMER_CLOCK_SELECT: next_rdata = timer_clock_select;
		default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sfr_rdata <= 8'h00;
			o_timer0_overflow <= 1'b0;
			o_timer1_overflow <= 1'b0;
			o_timer0_high_overflow <= 1'b0;
			o_timer0_irq <= 1'b0;
			o_timer1_irq <= 1'b0;
			o_ext_irq_a <= 1'b0;
			o_ext_irq_b <= 1'b0;
		end else begin
			o_sfr_rdata <= next_rdata;
			o_timer0_overflow <= ovf0;
			// Timer 1 pulse is kept even while its flag is blocked
			o_timer1_overflow <= ovf1;
			o_timer0_high_overflow <= ovf0h;
			o_timer0_irq <= timer_control_status[`BIT_TIMER0_OVERFLOW_FLAG];
			o_timer1_irq <= timer_control_status[`BIT_TIMER1_OVERFLOW_FLAG];
			o_ext_irq_a <= timer_control_status[`BIT_EXT_IRQ_A_FLAG];
			o_ext_irq_b <= timer_control_status[`BIT_EXT_IRQ_B_FLAG];
		end
	end
endmodule // dual_legacy_counter_timer

// *** bench/sfr_cpu_model.sv ***
`timescale 1ns/10ps
module sfr_cpu_model (
	input wire i_sys_clk,
	input wire [7:0] i_sfr_rdata,
	output logic [7:0] o_sfr_addr,
	output logic o_sfr_wr,
	output logic [7:0] o_sfr_wdata,
	output logic [3:0] o_vector
);
	initial begin
		o_sfr_addr = 8'h00;
		o_sfr_wr = 1'b0;
		o_sfr_wdata = 8'h00;
		o_vector = 4'h0;
	end
	// ----------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------
	// Address and data hold through the edge that takes the write
	task wr_reg(input logic [7:0] a, input logic [7:0] v);
		begin
			@(posedge i_sys_clk);
			o_sfr_addr <= a;
			o_sfr_wdata <= v;
			o_sfr_wr <= 1'b1;
			@(posedge i_sys_clk);
			o_sfr_wr <= 1'b0;
		end
	endtask
	task rd_reg(input logic [7:0] a, output logic [7:0] v);
		begin
			@(posedge i_sys_clk);
			o_sfr_addr <= a;
			@(posedge i_sys_clk);
			#1 v = i_sfr_rdata;
		end
	endtask
	task vector(input int i);
		begin
			@(posedge i_sys_clk);
			o_vector[i] <= 1'b1;
			@(posedge i_sys_clk);
			o_vector[i] <= 1'b0;
		end
	endtask
endmodule // sfr_cpu_model

// *** bench/dual_legacy_counter_timer_assertions.sv ***
`timescale 1ns/10ps
module timer_port_checker (
	input wire i_sys_clk,
	input wire i_arst_n,
	input wire [7:0] i_sfr_addr,
	input wire i_sfr_wr,
	input wire [7:0] i_sfr_wdata,
	input wire [7:0] o_sfr_rdata,
	input wire i_vector_ext_a,
	input wire i_ext_irq_in_a,
	input wire i_ext_irq_a_polarity,
	input wire o_timer0_overflow,
	input wire o_timer1_overflow,
	input wire o_timer0_high_overflow,
	input wire o_timer0_irq,
	input wire o_timer1_irq,
	input wire o_ext_irq_a
);
	// Shadow of the type bit: the register itself is not visible here
	reg type_a;
	wire act_a;
	assign act_a = (i_ext_irq_in_a == i_ext_irq_a_polarity);
	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			type_a <= 1'b0;
		end else if (i_sfr_wr && i_sfr_addr == 8'h88) begin
			type_a <= i_sfr_wdata[0];
		end
	end
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	a_ovf0_pulse: assert property (
		o_timer0_overflow |=> !o_timer0_overflow)
		else $error("timer0 overflow pulse too long");
	a_ovf1_pulse: assert property (
		o_timer1_overflow |=> !o_timer1_overflow)
		else $error("timer1 overflow pulse too long");
	a_high_ovf_pulse: assert property (
		o_timer0_high_overflow |=> !o_timer0_high_overflow)
		else $error("split high overflow pulse too long");
	a_ovf0_sets_irq: assert property (
		o_timer0_overflow |-> ##[0:2] o_timer0_irq)
		else $error("timer0 overflow without flag");
	a_high_sets_irq1: assert property (
		o_timer0_high_overflow |-> ##[0:2] o_timer1_irq)
		else $error("split high overflow without timer1 flag");
	a_level_flag_set: assert property (
		(!type_a && act_a) [*6] |-> o_ext_irq_a)
		else $error("level input active but flag low");
	a_edge_vec_clear: assert property (
		(type_a && !act_a) [*6] ##0 i_vector_ext_a |=> ##1 !o_ext_irq_a)
		else $error("edge flag not cleared by vectoring");
	a_unmapped_zero: assert property (
		(i_sfr_addr < 8'h88 || i_sfr_addr > 8'h8e) |=> o_sfr_rdata == 8'h00)
		else $error("unmapped address read nonzero");
	a_config_readback: assert property (
		i_sfr_wr && (i_sfr_addr == 8'h89 || i_sfr_addr == 8'h8e)
		##1 (i_sfr_addr == $past(i_sfr_addr) && !i_sfr_wr)
		|=> o_sfr_rdata == $past(i_sfr_wdata, 2))
		else $error("config register readback wrong");
endmodule // timer_port_checker
bind dual_legacy_counter_timer timer_port_checker u_checker (
	.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_sfr_addr(i_sfr_addr),
	.i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
	.o_sfr_rdata(o_sfr_rdata), .i_vector_ext_a(i_vector_ext_a),
	.i_ext_irq_in_a(i_ext_irq_in_a),
	.i_ext_irq_a_polarity(i_ext_irq_a_polarity),
	.o_timer0_overflow(o_timer0_overflow),
	.o_timer1_overflow(o_timer1_overflow),
	.o_timer0_high_overflow(o_timer0_high_overflow),
	.o_timer0_irq(o_timer0_irq), .o_timer1_irq(o_timer1_irq),
	.o_ext_irq_a(o_ext_irq_a)
);

// *** bench/dual_legacy_counter_timer_bench.sv ***
`timescale 1ns/10ps
module dual_legacy_counter_timer_bench;
	logic i_sys_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic in_a = 1'b1;
	logic in_b = 1'b0;
	logic [1:0] pins = 2'b11;
	logic [7:0] addr, wdata, rdata, d;
	logic wr;
	logic [3:0] vec;
	wire ov0, ov1, hov, irq0, irq1, ea, eb;
	wire [3:0] evs;
	int fail_count = 0;
	int n_tests = 0;
	int k;
	// Row: write flag, address, data, expected read
	logic [31:0] rows [0:11] = '{32'h0088_0000, 32'h0089_0000,
		32'h008a_0000, 32'h008e_0000, 32'h0189_a5a5, 32'h018e_f3f3,
		32'h018a_3c3c, 32'h018b_c3c3, 32'h018c_5a5a, 32'h018d_a5a5,
		32'h0190_ff00, 32'h0188_0404};
	assign evs = {ov1, ea, hov, ov0};
	always #20 i_sys_clk = ~i_sys_clk;
	dual_legacy_counter_timer u_dual_legacy_counter_timer (
		.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_sfr_addr(addr),
		.i_sfr_wr(wr), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
		.i_vector_timer0(vec[0]), .i_vector_timer1(vec[1]),
		.i_vector_ext_a(vec[2]), .i_vector_ext_b(vec[3]),
		.i_ext_irq_in_a(in_a), .i_ext_irq_in_b(in_b),
		.i_ext_irq_a_polarity(1'b0), .i_ext_irq_b_polarity(1'b1),
		.i_count_pin_a(pins[0]), .i_count_pin_b(pins[1]),
		.i_ext_osc_clk(1'b0), .o_timer0_overflow(ov0),
		.o_timer1_overflow(ov1), .o_timer0_high_overflow(hov),
		.o_timer0_irq(irq0), .o_timer1_irq(irq1), .o_ext_irq_a(ea),
		.o_ext_irq_b(eb));
	sfr_cpu_model u_sfr_cpu_model (.i_sys_clk(i_sys_clk),
		.i_sfr_rdata(rdata), .o_sfr_addr(addr), .o_sfr_wr(wr),
		.o_sfr_wdata(wdata), .o_vector(vec));
	task check(input string n, input logic [7:0] e, input logic [7:0] g);
		begin
			n_tests++;
			if (g !== e) begin
				fail_count++;
				$display("MISMATCH %s exp %h got %h", n, e, g);
			end
		end
	endtask
	task w(input logic [7:0] a, input logic [7:0] v);
		u_sfr_cpu_model.wr_reg(a, v);
	endtask
	task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
		begin
			u_sfr_cpu_model.rd_reg(a, d);
			check(n, e, d);
		end
	endtask
	// Low level held three cycles, high level four, inside the pin rate limit
	task pulses(input int b, input int n);
		begin
			for (int j = 0; j < n; j++) begin
				@(posedge i_sys_clk) pins[b] <= 1'b0;
				repeat (3) @(posedge i_sys_clk);
				pins[b] <= 1'b1;
				repeat (3) @(posedge i_sys_clk);
			end
			repeat (4) @(posedge i_sys_clk);
			#1;
		end
	endtask
	task wait_ev(input int i);
		begin
			k = 0;
			do begin
				@(posedge i_sys_clk);
				#1 k++;
			end while (evs[i] !== 1'b1 && k < 20);
		end
	endtask
	task results;
		begin
			if (fail_count == 0 && n_tests > 0) begin
				$display("Testbench passed");
			end else begin
				$display("Testbench failed");
			end
			$finish;
		end
	endtask
	initial begin
		repeat (20000) @(posedge i_sys_clk);
		fail_count++;
		results;
	end
	initial begin
		repeat (2) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			if (rows[i][24]) begin
				w(rows[i][23:16], rows[i][15:8]);
			end
			rchk("reg", rows[i][23:16], rows[i][7:0]);
		end
		w(8'h89, 8'h01);
		w(8'h8e, 8'h04);
		w(8'h8c, 8'hff);
		w(8'h8a, 8'hfd);
		w(8'h88, 8'h10);
		wait_ev(0);
		check("ovf16", 8'h01, {7'h0, ov0});
		@(posedge i_sys_clk);
		#1 check("irq16", 8'h01, {7'h0, irq0});
		w(8'h89, 8'h04);
		w(8'h8a, 8'h1e);
		w(8'h8c, 8'hff);
		w(8'h88, 8'h10);
		pulses(0, 3);
		check("irq13", 8'h01, {7'h0, irq0});
		w(8'h88, 8'h20);
		rchk("tl0_13", 8'h8a, 8'h01);
		rchk("th0_13", 8'h8c, 8'h00);
		u_sfr_cpu_model.vector(0);
		repeat (3) @(posedge i_sys_clk);
		#1 check("vec0", 8'h00, {7'h0, irq0});
		w(8'h89, 8'h06);
		w(8'h8c, 8'hfe);
		w(8'h8a, 8'hff);
		w(8'h88, 8'h10);
		pulses(0, 1);
		check("irq_rl", 8'h01, {7'h0, irq0});
		w(8'h88, 8'h00);
		rchk("tl0_rl", 8'h8a, 8'hfe);
		rchk("th0_rl", 8'h8c, 8'hfe);
		w(8'h89, 8'hc0);
		w(8'h8b, 8'h00);
		w(8'h8d, 8'h00);
		w(8'h88, 8'h40);
		pulses(1, 2);
		rchk("gate_shut", 8'h8b, 8'h00);
		@(posedge i_sys_clk) in_b <= 1'b1;
		pulses(1, 2);
		w(8'h88, 8'h00);
		rchk("gate_open", 8'h8b, 8'h02);
		@(posedge i_sys_clk) in_b <= 1'b0;
		w(8'h89, 8'h33);
		w(8'h8b, 8'h07);
		w(8'h8e, 8'h04);
		w(8'h8c, 8'hfe);
		w(8'h88, 8'h40);
		wait_ev(1);
		check("split_ovf", 8'h01, {7'h0, hov});
		@(posedge i_sys_clk);
		#1 check("split_irq1", 8'h01, {7'h0, irq1});
		u_sfr_cpu_model.vector(1);
		repeat (3) @(posedge i_sys_clk);
		#1 check("vec1", 8'h00, {7'h0, irq1});
		repeat (100) @(posedge i_sys_clk);
		rchk("t1_stopped", 8'h8b, 8'h07);
		w(8'h88, 8'h01);
		@(posedge i_sys_clk) in_a <= 1'b0;
		wait_ev(2);
		check("edge_set", 8'h01, {7'h0, ea});
		@(posedge i_sys_clk) in_a <= 1'b1;
		repeat (8) @(posedge i_sys_clk);
		#1 check("edge_hold", 8'h01, {7'h0, ea});
		u_sfr_cpu_model.vector(2);
		repeat (3) @(posedge i_sys_clk);
		#1 check("edge_clr", 8'h00, {7'h0, ea});
		w(8'h88, 8'h00);
		@(posedge i_sys_clk) in_a <= 1'b0;
		repeat (8) @(posedge i_sys_clk);
		#1 check("level_set", 8'h01, {7'h0, ea});
		@(posedge i_sys_clk) in_a <= 1'b1;
		// Timer 1 in reload while timer 0 is split: pulse but no flag
		w(8'h88, 8'h00);
		w(8'h8d, 8'hfe);
		w(8'h8b, 8'hfd);
		w(8'h8e, 8'h0c);
		w(8'h89, 8'h23);
		wait_ev(3);
		check("split_t1_ovf", 8'h01, {7'h0, ov1});
		repeat (2) @(posedge i_sys_clk);
		#1 check("split_t1_noflag", 8'h00, {7'h0, irq1});
		w(8'h88, 8'h04);
		@(posedge i_sys_clk) in_b <= 1'b1;
		repeat (6) @(posedge i_sys_clk);
		#1 check("edge_b", 8'h01, {7'h0, eb});
		@(posedge i_sys_clk) in_b <= 1'b0;
		u_sfr_cpu_model.vector(3);
		repeat (3) @(posedge i_sys_clk);
		#1 check("vec_b", 8'h00, {7'h0, eb});
		results;
	end
endmodule // dual_legacy_counter_timer_bench
